//--- rtl/boot_cfg_pkg.sv
// Purpose: Shared constants for the boot loader
// Assumes: 125 MHz system clock, APB slave with 32-bit data
// Notes:   Offsets are byte addresses of aligned words

// =====================================================================
// Package
// =====================================================================
package boot_cfg_pkg;

    // Clock and release delay
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned BOOT_DELAY_US    = 15;
    localparam int unsigned BOOT_DELAY_CYC   = BOOT_DELAY_US * CLK_MHZ;

    // Register byte offsets
    localparam logic [7:0]  OFS_PLL_CFG      = 8'h00;
    localparam logic [7:0]  OFS_STATUS       = 8'h04;
    localparam logic [7:0]  OFS_ENTRY        = 8'h08;
    localparam logic [7:0]  OFS_CRC          = 8'h0c;
    localparam logic [7:0]  OFS_SIZE         = 8'h10;
    localparam logic [7:0]  OFS_CLKDIV0      = 8'h14;

    // PLL field positions
    localparam int unsigned PLL_R_LSB        = 0;
    localparam int unsigned PLL_F_LSB        = 8;
    localparam int unsigned PLL_OD_LSB       = 23;

    // Mode pin feedback values
    localparam logic [11:0] F_MODE00         = 12'h09f;
    localparam logic [11:0] F_MODE11         = 12'h03f;
    localparam logic [11:0] F_MODE10         = 12'h01f;
    localparam logic [11:0] F_MODE01         = 12'h00f;
    localparam logic [2:0]  OD_RESET         = 3'h1;
    localparam logic [5:0]  R_RESET          = 6'h00;

    // Security bit selecting the OTP source
    localparam int unsigned SEC_BOOT_BIT     = 5;

    // Boot image constants
    localparam logic [31:0] CRC_SKIP_WORD    = 32'h0d15ab1e;
    localparam logic [31:0] CRC_POLY         = 32'hedb88320;
    localparam logic [31:0] CRC_INIT         = 32'hffffffff;
    localparam logic [31:0] ENTRY_ADDR       = 32'h00000000;

    // Reference divider reset value
    localparam logic [7:0]  CLKDIV0_RESET    = 8'h00;

endpackage

//--- rtl/crc32_byte.sv
// Purpose: One-byte step of the reflected CRC-32
// Assumes: Combinational, once per byte
// Notes:   Polynomial from the package

`timescale 1ns/1ps

module crc32_byte
    import boot_cfg_pkg::*;
(
    input  wire logic [31:0] crc_in,     // Running remainder
    input  wire logic [7:0]  data_in,    // Next byte, lsb first
    output logic      [31:0] crc_out     // Updated remainder
);

    // =================================================================
    // One reflected stage per bit
    // =================================================================
    logic [31:0] stage [0:8];            // Remainder after each bit

    assign stage[0] = crc_in;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            logic fb;                    // Feedback bit
            assign fb = stage[gi][0] ^ data_in[gi];
            assign stage[gi+1] = (stage[gi] >> 1) ^ (fb ? CRC_POLY : 32'h0);
        end
    endgenerate

    assign crc_out = stage[8];

endmodule

//--- rtl/image_loader.sv
// Purpose: Builds image words and writes program RAM
// Assumes: Selected byte stream, valid/ready
// Notes:   Words assemble lsb first

`timescale 1ns/1ps

module image_loader
    import boot_cfg_pkg::*;
#(
    parameter int unsigned ADDR_W = 16   // RAM word address width
) (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic              start,      // Begin a new image
    input  wire logic [7:0]        byte_data,  // Image byte
    input  wire logic              byte_valid, // Byte present
    output logic                   byte_ready, // Byte accepted
    output logic                   ram_we,     // RAM write strobe
    output logic      [ADDR_W-1:0] ram_addr,   // RAM word address
    output logic      [31:0]       ram_wdata,  // RAM write data
    output logic                   done,       // Image complete, pulse
    output logic                   crc_ok,     // Check passed or skipped
    output logic                   crc_skip,   // Check word was bypass
    output logic      [31:0]       size_words, // Program length seen
    output logic      [31:0]       crc_calc    // Computed check value
);

    initial begin
        if (ADDR_W < 2 || ADDR_W > 30) $error("ADDR_W out of range");
    end

    // =================================================================
    // Parser state
    // =================================================================
    typedef enum logic [1:0] {P_IDLE, P_SIZE, P_PROG, P_CHECK} parse_e;
    parse_e      st_q;               // Current field
    logic [1:0]  bcnt_q;             // Byte index within word
    logic [31:0] word_q;             // Word being assembled
    logic [31:0] left_q;             // Words left
    logic [31:0] crc_q;              // Running remainder
    logic [31:0] crc_nx;             // Next remainder
    logic [31:0] word_nx;            // Next word
    logic        take;               // Byte taken

    assign byte_ready = (st_q != P_IDLE);
    assign take       = byte_valid && byte_ready;
    // Lsb first: new byte enters at the top
    assign word_nx    = {byte_data, word_q[31:8]};

    crc32_byte u_crc (
        .crc_in  (crc_q),
        .data_in (byte_data),
        .crc_out (crc_nx)
    );

    // Covers size and program, not the check word
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crc_q <= CRC_INIT;
        end else if (start) begin
            crc_q <= CRC_INIT;
        end else if (take && st_q != P_CHECK) begin
            crc_q <= crc_nx;
        end
    end

    // Field walk
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= P_IDLE;
            bcnt_q     <= 2'h0;
            word_q     <= 32'h0;
            left_q     <= 32'h0;
            ram_we     <= 1'b0;
            ram_addr   <= '0;
            ram_wdata  <= 32'h0;
            done       <= 1'b0;
            crc_ok     <= 1'b0;
            crc_skip   <= 1'b0;
            size_words <= 32'h0;
            crc_calc   <= 32'h0;
        end else begin
            ram_we <= 1'b0;
            done   <= 1'b0;
            if (start) begin
                st_q     <= P_SIZE;
                bcnt_q   <= 2'h0;
                ram_addr <= ENTRY_ADDR[ADDR_W-1:0];
                crc_ok   <= 1'b0;
                crc_skip <= 1'b0;
            end else if (take) begin
                word_q <= word_nx;
                bcnt_q <= bcnt_q + 2'h1;
                if (bcnt_q == 2'h3) begin
                    case (st_q)
                        P_SIZE: begin
                            size_words <= word_nx;
                            left_q     <= word_nx;
                            st_q <= (word_nx == 32'h0) ? P_CHECK : P_PROG;
                        end
                        P_PROG: begin
                            ram_we    <= 1'b1;
                            ram_wdata <= word_nx;
                            if (ram_we) begin
                                ram_addr <= ram_addr + 1'b1;
                            end
                            left_q <= left_q - 32'h1;
                            if (left_q == 32'h1) begin
                                st_q <= P_CHECK;
                            end
                        end
                        P_CHECK: begin
                            crc_calc <= ~crc_q;
                            crc_skip <= (word_nx == CRC_SKIP_WORD);
                            crc_ok   <= (word_nx == CRC_SKIP_WORD) ||
                                        (word_nx == ~crc_q);
                            done     <= 1'b1;
                            st_q     <= P_IDLE;
                        end
                        default: st_q <= P_IDLE;
                    endcase
                end
            end else if (ram_we) begin
                ram_addr <= ram_addr + 1'b1;
            end
        end
    end

endmodule

//--- rtl/boot_pll_config_loader.sv
// Purpose: Reset release, PLL strap and boot loader
// Assumes: Pins arrive asynchronously; APB master on clk_sys
// Notes:   PLL and divider appear as config outputs

`timescale 1ns/1ps

// Function
// - Pull-downs on during reset
// - Boot after fixed release delay
// - Security bit picks OTP source
// - Length, words, check word
// - Bypass word skips CRC
// - Length, check word lsb first
// - Load and start at address zero
// - CRC over length and program
// - Reflected CRC-32, inverted result
// - PLL feeds switch and tiles
// - Mode pins pick PLL ratio
// - Tile clock from PLL fields
// - PLL fields software rewritable
// - Divider zero is reference clock
// - Ports start on divider zero
// - Secure boot starts at zero
module boot_pll_config_loader
    import boot_cfg_pkg::*;
#(
    parameter int unsigned GPIO_N     = 16,             // GPIO pin count
    parameter int unsigned PORT_N     = 8,              // I/O port count
    parameter int unsigned ADDR_W     = 16,             // RAM address width
    parameter int unsigned BOOT_DELAY = BOOT_DELAY_CYC  // Release delay
) (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic [1:0]        mode_pins,      // Ratio strap pins
    input  wire logic [31:0]       security_word,  // Loaded security reg
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [31:0]       prdata,
    // Boot byte streams
    input  wire logic [7:0]        otp_data,
    input  wire logic              otp_valid,
    output logic                   otp_ready,
    input  wire logic [7:0]        flash_data,
    input  wire logic              flash_valid,
    output logic                   flash_ready,
    // Program RAM write port
    output logic                   ram_we,
    output logic      [ADDR_W-1:0] ram_addr,
    output logic      [31:0]       ram_wdata,
    // Core start and status
    output logic                   core_run,
    output logic      [31:0]       core_pc,
    output logic                   boot_error,
    // Clocking configuration
    output logic      [2:0]        pll_output_divider,
    output logic      [11:0]       pll_feedback,
    output logic      [5:0]        pll_ref_divider,
    output logic      [7:0]        clkdiv0_ratio,
    output logic      [PORT_N-1:0] port_on_clkdiv0,
    output logic      [GPIO_N-1:0] gpio_pulldown
);

    initial begin
        if (GPIO_N == 0 || PORT_N == 0) $error("GPIO_N/PORT_N zero");
        if (BOOT_DELAY < 2 || BOOT_DELAY > 32'h00ffffff)
            $error("BOOT_DELAY out of range");
    end

    // =================================================================
    // Pin synchronisers
    // =================================================================
    logic [1:0] mode_s1_q;               // First stage, read only by s2
    logic [1:0] mode_s2_q;               // Usable mode level
    logic       sec_s1_q;
    logic       sec_s2_q;

    // Async straps: two flops before use
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
            sec_s1_q  <= 1'b0;
            sec_s2_q  <= 1'b0;
        end else begin
            mode_s1_q <= mode_pins;
            mode_s2_q <= mode_s1_q;
            sec_s1_q  <= security_word[SEC_BOOT_BIT];
            sec_s2_q  <= sec_s1_q;
        end
    end

    // =================================================================
    // Boot sequencer
    // =================================================================
    typedef enum logic [2:0] {
        B_RESET, B_DELAY, B_LOAD, B_RUN, B_FAIL
    } boot_e;
    boot_e       bst_q;                  // Boot phase
    logic [23:0] dly_q;                  // Release delay counter
    logic        src_otp_q;              // Latched boot source
    logic        ld_start;               // Start pulse to loader
    logic        ld_done;
    logic        ld_ok;
    logic        ld_skip;
    logic [31:0] ld_size;
    logic [31:0] ld_crc;
    logic [7:0]  ld_data;
    logic        ld_valid;
    logic        ld_ready;
    logic        ld_we;
    logic [ADDR_W-1:0] ld_addr;
    logic [31:0] ld_wdata;

    assign ld_start = (bst_q == B_DELAY) && (dly_q == 24'h0);

    // Release, wait, then load
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bst_q     <= B_RESET;
            dly_q     <= 24'h0;
            src_otp_q <= 1'b0;
        end else begin
            case (bst_q)
                B_RESET: begin
                    dly_q <= BOOT_DELAY[23:0] - 24'h1;
                    bst_q <= B_DELAY;
                end
                B_DELAY: begin
                    src_otp_q <= sec_s2_q;
                    if (dly_q == 24'h0) begin
                        bst_q <= B_LOAD;
                    end else begin
                        dly_q <= dly_q - 24'h1;
                    end
                end
                B_LOAD: begin
                    if (ld_done) begin
                        bst_q <= ld_ok ? B_RUN : B_FAIL;
                    end
                end
                default: bst_q <= bst_q;                // Run/fail hold
            endcase
        end
    end

    // Selected source feeds loader; a byte counts only at a handshake
    assign ld_data  = src_otp_q ? otp_data : flash_data;
    assign ld_valid = (bst_q == B_LOAD) &&
                      (src_otp_q ? otp_valid && otp_ready
                                 : flash_valid && flash_ready);

    image_loader #(
        .ADDR_W (ADDR_W)
    ) u_loader (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .start      (ld_start),
        .byte_data  (ld_data),
        .byte_valid (ld_valid),
        .byte_ready (ld_ready),
        .ram_we     (ld_we),
        .ram_addr   (ld_addr),
        .ram_wdata  (ld_wdata),
        .done       (ld_done),
        .crc_ok     (ld_ok),
        .crc_skip   (ld_skip),
        .size_words (ld_size),
        .crc_calc   (ld_crc)
    );

    // Registered outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            otp_ready   <= 1'b0;
            flash_ready <= 1'b0;
            ram_we      <= 1'b0;
            ram_addr    <= '0;
            ram_wdata   <= 32'h0;
            core_run    <= 1'b0;
            core_pc     <= ENTRY_ADDR;
            boot_error  <= 1'b0;
        end else begin
            // Ready flop alternates: one byte per two cycles
            otp_ready   <= ld_ready && src_otp_q && (bst_q == B_LOAD)
                           && !otp_ready;
            flash_ready <= ld_ready && !src_otp_q && (bst_q == B_LOAD)
                           && !flash_ready;
            ram_we      <= ld_we;
            ram_addr    <= ld_addr;
            ram_wdata   <= ld_wdata;
            core_pc     <= ENTRY_ADDR;
            core_run    <= (bst_q == B_LOAD && ld_done && ld_ok)
                           || core_run;
            boot_error  <= (bst_q == B_LOAD && ld_done && !ld_ok)
                           || boot_error;
        end
    end

    // =================================================================
    // Pull-downs and port clock attachment
    // =================================================================
    // Pull-downs held until the reset phase ends
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gpio_pulldown   <= {GPIO_N{1'b1}};
            port_on_clkdiv0 <= {PORT_N{1'b1}};
        end else if (bst_q == B_RESET) begin
            gpio_pulldown   <= {GPIO_N{1'b1}};
        end else begin
            gpio_pulldown   <= {GPIO_N{1'b0}};
        end
    end

    // =================================================================
    // PLL and reference divider registers
    // =================================================================
    logic strap_done_q;                  // Mode ratio applied once
    logic apb_wr;                        // Access-phase write
    assign apb_wr = psel && penable && pwrite;

    // Strap at end of delay, once synchronised; then software owns it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_done_q       <= 1'b0;
            pll_output_divider <= OD_RESET;
            pll_feedback       <= F_MODE00;
            pll_ref_divider    <= R_RESET;
        end else if (!strap_done_q && ld_start) begin
            strap_done_q <= 1'b1;
            case (mode_s2_q)
                2'b00:   pll_feedback <= F_MODE00;
                2'b11:   pll_feedback <= F_MODE11;
                2'b10:   pll_feedback <= F_MODE10;
                default: pll_feedback <= F_MODE01;
            endcase
            pll_output_divider <= OD_RESET;
            pll_ref_divider    <= R_RESET;
        end else if (apb_wr && paddr == OFS_PLL_CFG) begin
            // Tile clock = osc*(F+1)/2/(R+1)/(OD+1), applied by the PLL
            pll_output_divider <= pwdata[PLL_OD_LSB+:3];
            pll_feedback       <= pwdata[PLL_F_LSB+:12];
            pll_ref_divider    <= pwdata[PLL_R_LSB+:6];
        end
    end

    // Divider zero; reset value gives 100MHz
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clkdiv0_ratio <= CLKDIV0_RESET;
        end else if (apb_wr && paddr == OFS_CLKDIV0) begin
            clkdiv0_ratio <= pwdata[7:0];
        end
    end

    // =================================================================
    // APB read path and response
    // =================================================================
    // No wait state: pready registered from the setup cycle, high in the first access cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                if (paddr == OFS_PLL_CFG) begin
                    prdata <= 32'(pll_output_divider) << PLL_OD_LSB |
                              32'(pll_feedback) << PLL_F_LSB |
                              32'(pll_ref_divider) << PLL_R_LSB;
                end else if (paddr == OFS_STATUS) begin
                    prdata <= {26'h0, ld_skip, src_otp_q, boot_error,
                               core_run, (bst_q == B_LOAD),
                               strap_done_q};
                end else if (paddr == OFS_ENTRY) begin
                    prdata <= core_pc;
                end else if (paddr == OFS_CRC) begin
                    prdata <= ld_crc;
                end else if (paddr == OFS_SIZE) begin
                    prdata <= ld_size;
                end else if (paddr == OFS_CLKDIV0) begin
                    prdata <= {24'h0, clkdiv0_ratio};
                end else begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule

//--- test/byte_source_model.sv
// Purpose: Flash or OTP byte source
// Assumes: Image is size word, program words, check word
// Notes:   Idle data is the last byte inverted

`timescale 1ns/1ps

// ====================
// Source model
module byte_source_model
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        ready,   // Loader takes a byte
    input  wire logic [31:0] size_w,  // Program length in words
    input  wire logic [31:0] base_w,  // First program word
    input  wire logic [31:0] check_w, // Trailing check word
    output logic      [7:0]  data,    // Offered byte
    output logic             valid    // Byte offered
);
    int unsigned idx_q;    // Bytes handed over so far
    logic [31:0] cur_word; // Current word
    logic [7:0]  last_q;   // Last byte, for idle
    // Field order
    always_comb begin
        if (idx_q < 4)
            cur_word = size_w;
        else if (idx_q < 4 + 4 * size_w)
            cur_word = base_w + 32'((idx_q - 4) / 4);
        else
            cur_word = check_w;
    end
    // Offer holds until taken; a stale byte would hide a slip
    assign valid = arst_n && (idx_q < 8 + 4 * size_w);
    assign data  = valid ? cur_word[8 * (idx_q % 4) +: 8] : ~last_q;
    // Advance on handshake
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idx_q  <= 0;
            last_q <= 8'h00;
        end else if (valid && ready) begin
            idx_q  <= idx_q + 1;
            last_q <= data;
        end
    end
endmodule

//--- test/boot_loader_sva.sv
// Purpose: Port checker
// Assumes: One clock domain, clk_sys
// Notes:   Bound to the top module below

`timescale 1ns/1ps

// ====================
// Checker
module boot_loader_sva
    import boot_cfg_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [31:0] security_word,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        otp_ready,
    input wire logic        flash_ready,
    input wire logic        ram_we,
    input wire logic        core_run,
    input wire logic [31:0] core_pc,
    input wire logic        boot_error
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_entry_pc: assert property (core_run |-> core_pc == ENTRY_ADDR)
        else $error("start address wrong");
    a_run_holds: assert property (core_run |=> core_run)
        else $error("start dropped");
    a_err_blocks: assert property (boot_error |=> boot_error && !core_run)
        else $error("error let start");
    a_one_source: assert property (!(otp_ready && flash_ready))
        else $error("both sources ready");
    a_otp_select: assert property (otp_ready |-> security_word[SEC_BOOT_BIT])
        else $error("otp while clear");
    a_flash_select: assert property (flash_ready |-> !security_word[SEC_BOOT_BIT])
        else $error("flash while set");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    a_no_late_load: assert property (core_run |-> !ram_we)
        else $error("late ram write");
endmodule

bind boot_pll_config_loader boot_loader_sva chk_u (.clk_sys, .arst_n,
    .security_word, .psel, .penable, .pready, .otp_ready, .flash_ready,
    .ram_we, .core_run, .core_pc, .boot_error);

//--- test/tb_boot_pll_config_loader.sv
// Purpose: Bench for the boot loader
// Assumes: Release delay shortened to 4 cycles
// Notes:   Four boots cover every strap and check-word kind

`timescale 1ns/1ps

// ====================
// Bench
module tb_boot_pll_config_loader;
    import boot_cfg_pkg::*;
    localparam logic [1:0]  MODES [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
    localparam logic [11:0] FS [4] = '{F_MODE00, F_MODE11, F_MODE10, F_MODE01};
    localparam int          SIZES [4] = '{2, 0, 3, 1}; // Zero is the edge
    localparam int          KINDS [4] = '{0, 1, 2, 0}; // Good, skip, bad
    logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
    logic        otp_valid, otp_ready, flash_valid, flash_ready, er;
    logic        ram_we, core_run, boot_error;
    logic [1:0]  mode_pins;
    logic [2:0]  pll_output_divider;
    logic [5:0]  pll_ref_divider;
    logic [11:0] pll_feedback;
    logic [7:0]  paddr, otp_data, flash_data, clkdiv0_ratio, port_on_clkdiv0;
    logic [15:0] ram_addr, gpio_pulldown;
    logic [31:0] security_word, pwdata, prdata, core_pc, ram_wdata, rd;
    logic [31:0] sz, ck, bs;
    int          err_total, checks, wr_n, cyc;
    boot_pll_config_loader #(.BOOT_DELAY(4)) dut_u (.clk_sys, .arst_n,
        .mode_pins, .security_word, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .otp_data, .otp_valid,
        .otp_ready, .flash_data, .flash_valid, .flash_ready, .ram_we,
        .ram_addr, .ram_wdata, .core_run, .core_pc, .boot_error,
        .pll_output_divider, .pll_feedback, .pll_ref_divider,
        .clkdiv0_ratio, .port_on_clkdiv0, .gpio_pulldown);
    byte_source_model otp_u (.clk_sys, .arst_n, .ready(otp_ready),
        .size_w(sz), .base_w(32'ha0000000), .check_w(ck), .data(otp_data),
        .valid(otp_valid));
    byte_source_model fl_u (.clk_sys, .arst_n, .ready(flash_ready),
        .size_w(sz), .base_w(32'h50000000), .check_w(ck), .data(flash_data),
        .valid(flash_valid));
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reference CRC
    function automatic logic [31:0] crc_of(input logic [31:0] s, b);
        logic [31:0] c, w;
        c = CRC_INIT;
        for (int k = 0; k < 4 + 4 * s; k++) begin
            w = (k < 4) ? s : b + 32'((k - 4) / 4);
            c = c ^ 32'(w[8 * (k % 4) +: 8]);
            for (int j = 0; j < 8; j++) c = (c >> 1) ^ (c[0] ? CRC_POLY : 0);
        end
        return ~c;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) if (++cyc == 3000) begin
        err_total++;
        complete_run();
    end
    // RAM writes in order from word zero
    always @(posedge clk_sys) if (ram_we === 1'b1) begin
        chk(32'(ram_addr), wr_n, "ram_addr");
        chk(ram_wdata, bs + wr_n, "ram_wdata");
        wr_n++;
    end
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, mode_pins} = '0;
        {security_word, sz, ck, bs, err_total, checks, wr_n, cyc} = '0;
        for (int i = 0; i < 4; i++) begin
            arst_n <= 1'b0;
            mode_pins <= MODES[i];
            security_word <= 32'(i % 2) << SEC_BOOT_BIT;
            bs = i[0] ? 32'ha0000000 : 32'h50000000;
            sz <= SIZES[i];
            ck <= KINDS[i] == 1 ? CRC_SKIP_WORD : crc_of(SIZES[i], bs) ^ (KINDS[i] == 2);
            wr_n = 0;
            repeat (12) @(posedge clk_sys);
            chk(32'(gpio_pulldown), 32'hffff, "pulldown");
            chk(32'(port_on_clkdiv0), 32'hff, "ports");
            arst_n <= 1'b1;
            do @(posedge clk_sys); while (core_run !== 1'b1 && boot_error !== 1'b1);
            repeat (3) @(posedge clk_sys);
            chk(32'(core_run), 32'(KINDS[i] != 2), "run");
            chk(32'(boot_error), 32'(KINDS[i] == 2), "error");
            chk(wr_n, SIZES[i], "words");
            chk(32'({pll_output_divider, pll_feedback, pll_ref_divider}),
                32'({OD_RESET, FS[i], R_RESET}), "strap");
            chk(32'(gpio_pulldown), 32'h0, "pulldown");
            apb(1'b0, OFS_CRC, 32'h0);
            chk(rd, crc_of(SIZES[i], bs), "crc");
            apb(1'b0, OFS_SIZE, 32'h0);
            chk(rd, SIZES[i], "size");
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(32'(rd[5:4]), 32'({KINDS[i] == 1, i[0]}), "source");
            $display("boot test %0d done", i);
        end
        apb(1'b1, OFS_PLL_CFG, 32'h01012305);
        apb(1'b0, OFS_PLL_CFG, 32'h0);
        chk(rd, 32'h01012305, "pll reg");
        chk(32'({pll_output_divider, pll_feedback, pll_ref_divider}),
            32'({3'h2, 12'h123, 6'h05}), "pll");
        apb(1'b0, OFS_CLKDIV0, 32'h0);
        chk(rd, 32'(CLKDIV0_RESET), "clkdiv0");
        apb(1'b0, OFS_ENTRY, 32'h0);
        chk(rd, ENTRY_ADDR, "entry");
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1, "slverr");
        $display("register test done");
        complete_run();
    end
endmodule
